// *** design/cts_top.sv ***
`timescale 1ns/1ps
module cts_top
  import cts_pkg::*;
(
  input wire logic clk, // 125 MHz clock
  input wire logic reset_n, // Async reset, active low
  input wire logic cycle_tick, // One pulse per program cycle
  input wire logic [11:0] rtc_year, // Clock year, full value
  input wire logic [3:0] rtc_month, // Clock month 1..12
  input wire logic [4:0] rtc_day, // Clock day 1..31
  input wire logic [2:0] rtc_wday, // Weekday, 0 Monday .. 6 Sunday
  input wire logic [4:0] rtc_hour, // Clock hour 0..23
  input wire logic [5:0] rtc_min, // Clock minute 0..59
  output logic weekly_q, // Weekly switch output
  output logic yearly_q, // Yearly switch output
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  logic [31:0] cam_r [3];
  logic [31:0] cam_nxt [3];
  logic wpulse_r, wpulse_nxt;
  logic [31:0] yon_r, yon_nxt, yoff_r, yoff_nxt;
  logic [2:0] ymode_r, ymode_nxt;
  logic rearm_r, rearm_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [7:0] waddr_r, waddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [10:0] last_hm_r, last_hm_nxt;
  logic seen_r, seen_nxt;
  logic new_minute;
  logic midnight;
  logic wk_q;
  logic yr_q;
  logic yr_done;

  // Byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // Date word legal only inside the accepted year range
  function automatic logic year_ok(input logic [31:0] w);
    year_ok = (w[CTS_DATE_YEAR +: 12] >= CTS_YEAR_MIN) && (w[CTS_DATE_YEAR +: 12] <= CTS_YEAR_MAX); // RULE5
  endfunction

  // ==========================================================
  // Clock sampling: events fire once per minute, not once per tick
  assign new_minute = cycle_tick && (!seen_r || last_hm_r != {rtc_hour, rtc_min}); // RULE16
  assign midnight = new_minute && (rtc_hour == 5'd0) && (rtc_min == 6'd0); // RULE6

  always_comb begin
    last_hm_nxt = cycle_tick ? {rtc_hour, rtc_min} : last_hm_r;
    seen_nxt = seen_r | cycle_tick;
  end

  // ==========================================================
  // AXI4-Lite slave and register file
  always_comb begin
    logic [31:0] nv;
    nv = '0;
    for (int i = 0; i < 3; i++) begin
      cam_nxt[i] = cam_r[i];
    end
    wpulse_nxt = wpulse_r;
    yon_nxt = yon_r;
    yoff_nxt = yoff_r;
    ymode_nxt = ymode_r;
    rearm_nxt = 1'b0;
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    // Address and data taken in either order
    if (s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      awready_nxt = 1'b0;
      waddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      wready_nxt = 1'b0;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (aw_held_r && w_held_r && !bvalid_r) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = CTS_RESP_OKAY;
      unique case ({waddr_r[7:2], 2'b00})
        CTS_CAM0_OFS, CTS_CAM1_OFS, CTS_CAM2_OFS: begin
          cam_nxt[waddr_r[3:2]] = merge(cam_r[waddr_r[3:2]], wdata_r, wstrb_r) & 32'h7fff_ffff;
        end
        CTS_WCTRL_OFS: begin
          if (wstrb_r[0]) begin
            wpulse_nxt = wdata_r[CTS_WCTRL_PULSE];
          end
        end
        CTS_YON_OFS, CTS_YOFF_OFS: begin
          // Out-of-range years are refused and the old date kept
          nv = merge((waddr_r[2] ? yoff_r : yon_r), wdata_r, wstrb_r) & 32'h0fff_0f1f;
          if (!year_ok(nv)) begin
            bresp_nxt = CTS_RESP_SLVERR; // RULE5
          end else if (waddr_r[2]) begin
            yoff_nxt = nv;
            rearm_nxt = 1'b1;
          end else begin
            yon_nxt = nv;
            rearm_nxt = 1'b1;
          end
        end
        CTS_YCTRL_OFS: begin
          if (wstrb_r[0]) begin
            ymode_nxt = wdata_r[2:0];
            rearm_nxt = 1'b1;
          end
        end
        CTS_STATUS_OFS: begin
          bresp_nxt = CTS_RESP_SLVERR;
        end
        default: begin
          bresp_nxt = CTS_RESP_DECERR;
        end
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
    // Read path: one outstanding read, answered the cycle after the address
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = CTS_RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        CTS_CAM0_OFS, CTS_CAM1_OFS, CTS_CAM2_OFS: rdata_nxt = cam_r[s_axi_araddr[3:2]];
        CTS_WCTRL_OFS: rdata_nxt = {31'd0, wpulse_r};
        CTS_YON_OFS: rdata_nxt = yon_r;
        CTS_YOFF_OFS: rdata_nxt = yoff_r;
        CTS_YCTRL_OFS: rdata_nxt = {29'd0, ymode_r};
        CTS_STATUS_OFS: rdata_nxt = {29'd0, yr_done, yr_q, wk_q};
        default: begin
          rdata_nxt = '0;
          rresp_nxt = CTS_RESP_DECERR;
        end
      endcase
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 3; i++) begin
        cam_r[i] <= CTS_CAM_RST;
      end
      wpulse_r <= 1'b0;
      yon_r <= CTS_YON_RST;
      yoff_r <= CTS_YOFF_RST;
      ymode_r <= 3'h0;
      rearm_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'b00;
      last_hm_r <= 11'h000;
      seen_r <= 1'b0;
    end else begin
      cam_r <= cam_nxt;
      wpulse_r <= wpulse_nxt;
      yon_r <= yon_nxt;
      yoff_r <= yoff_nxt;
      ymode_r <= ymode_nxt;
      rearm_r <= rearm_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      last_hm_r <= last_hm_nxt;
      seen_r <= seen_nxt;
    end
  end

  // ==========================================================
  // Timer engines
  cts_weekly #(.NCAM(3)) u_weekly (
    .clk(clk),
    .reset_n(reset_n),
    .tick(cycle_tick),
    .new_minute(new_minute),
    .wday(rtc_wday),
    .hour(rtc_hour),
    .minute(rtc_min),
    .cams({cam_r[2], cam_r[1], cam_r[0]}),
    .pulse(wpulse_r),
    .q(wk_q)
  );

  cts_yearly u_yearly (
    .clk(clk),
    .reset_n(reset_n),
    .tick(cycle_tick),
    .midnight(midnight),
    .year(rtc_year),
    .month(rtc_month),
    .day(rtc_day),
    .on_date(yon_r),
    .off_date(yoff_r),
    .mode(ymode_r),
    .rearm(rearm_r),
    .q(yr_q),
    .done(yr_done)
  );

  // Outputs straight from flops
  assign weekly_q = wk_q;
  assign yearly_q = yr_q;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ==========================================================
  // Checks
  year_guard_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
    year_ok(yon_r) && year_ok(yoff_r))
    else $error("stored date outside accepted years");
  one_minute_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE16
    (new_minute ##1 cycle_tick && {rtc_hour, rtc_min} == $past({rtc_hour, rtc_min})) |-> !new_minute)
    else $error("minute event repeated");
  bad_year_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
    (aw_held_r && w_held_r && !bvalid_r && waddr_r[7:3] == 5'b00010 &&
     !year_ok(merge((waddr_r[2] ? yoff_r : yon_r), wdata_r, wstrb_r) & 32'h0fff_0f1f))
    |=> bvalid_r && bresp_r == CTS_RESP_SLVERR && $stable(yon_r) && $stable(yoff_r))
    else $error("out-of-range year accepted");

  // Yearly output moves only on program cycles
  yr_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE16
    !cycle_tick |=> $stable(yr_q))
    else $error("yearly output moved without a tick");
  // A repeated minute never re-arms a weekly pulse
  wk_pulse_clear_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
    (wpulse_r && cycle_tick && !new_minute) |=> !wk_q)
    else $error("weekly pulse held over a repeated minute");
endmodule

// *** design/cts_weekly.sv ***
`timescale 1ns/1ps
module cts_weekly
  import cts_pkg::*;
#(
  parameter int NCAM = 3
) (
  input wire logic clk, // Clock
  input wire logic reset_n, // Async reset, active low
  input wire logic tick, // Program cycle strobe
  input wire logic new_minute, // First tick of a new minute
  input wire logic [2:0] wday, // Weekday, 0 is Monday
  input wire logic [4:0] hour, // Current hour
  input wire logic [5:0] minute, // Current minute
  input wire logic [NCAM*32-1:0] cams, // Packed cam words
  input wire logic pulse, // Shared pulse setting
  output logic q // Weekly switch output
);
  logic q_r;
  logic q_nxt;

  // Time match, ignoring an empty field
  function automatic logic time_hit(input logic set, input logic [4:0] h, input logic [5:0] m,
                                    input logic [4:0] ch, input logic [5:0] cm);
    time_hit = set && (h == ch) && (m == cm) && (h < 5'd24) && (m < 6'd60); // RULE2 RULE4
  endfunction

  // ==========================================================
  // Cam evaluation, later cams override earlier ones
  always_comb begin
    logic [31:0] c;
    logic day_ok;
    c = '0;
    day_ok = 1'b0;
    q_nxt = q_r;
    if (tick && pulse) begin
      q_nxt = 1'b0; // RULE3 RULE14
    end
    for (int i = 0; i < NCAM; i++) begin
      c = cams[i*32 +: 32];
      day_ok = (wday < 3'd7) && c[CTS_CAM_DAYS + int'(wday)]; // RULE1
      if (tick && new_minute && day_ok) begin // RULE16
        if (time_hit(c[CTS_CAM_ON_SET], c[CTS_CAM_ON_HR +: 5], c[CTS_CAM_ON_MN +: 6], hour, minute)) begin
          q_nxt = 1'b1; // RULE14 RULE15 RULE17
        end
        if (!pulse && time_hit(c[CTS_CAM_OFF_SET], c[CTS_CAM_OFF_HR +: 5], c[CTS_CAM_OFF_MN +: 6],
                               hour, minute)) begin
          q_nxt = 1'b0; // RULE14 RULE15
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

  // ==========================================================
  // Checks
  pulse_width_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
    (pulse && tick && !new_minute && q_r) |=> !q_r)
    else $error("weekly pulse outlived a program cycle");
  hold_between_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE16
    !tick |=> $stable(q_r))
    else $error("weekly output moved without a tick");
  top_cam_wins_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE15
    (tick && new_minute && (wday < 3'd7) && cams[2*32 + CTS_CAM_DAYS + int'(wday)] &&
     time_hit(cams[2*32 + CTS_CAM_ON_SET], cams[2*32 + CTS_CAM_ON_HR +: 5],
              cams[2*32 + CTS_CAM_ON_MN +: 6], hour, minute) &&
     !(!pulse && time_hit(cams[2*32 + CTS_CAM_OFF_SET], cams[2*32 + CTS_CAM_OFF_HR +: 5],
                          cams[2*32 + CTS_CAM_OFF_MN +: 6], hour, minute))) |=> q_r)
    else $error("highest cam on-time lost");
endmodule

// *** design/cts_yearly.sv ***
`timescale 1ns/1ps
module cts_yearly
  import cts_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic reset_n, // Async reset, active low
  input wire logic tick, // Program cycle strobe
  input wire logic midnight, // First tick at 00:00
  input wire logic [11:0] year, // Current year
  input wire logic [3:0] month, // Current month
  input wire logic [4:0] day, // Current day
  input wire logic [31:0] on_date, // On-date word
  input wire logic [31:0] off_date, // Off-date word
  input wire logic [2:0] mode, // Pulse, yearly, monthly
  input wire logic rearm, // Config written, clears one-shot
  output logic q, // Yearly switch output
  output logic done // Single pulse already emitted
);
  logic q_r;
  logic q_nxt;
  logic done_r;
  logic done_nxt;
  logic monthly;
  logic yearly;
  logic pulse;
  logic [11:0] on_y;
  logic [11:0] off_y;
  logic [8:0] on_md;
  logic [8:0] off_md;
  logic [8:0] now_md;
  logic in_span;
  logic on_ev;
  logic off_ev;

  assign monthly = mode[CTS_YCTRL_MONTHLY];
  assign yearly = mode[CTS_YCTRL_YEARLY];
  assign pulse = mode[CTS_YCTRL_PULSE];
  // Year, month, day as ordered fields
  assign on_y = on_date[CTS_DATE_YEAR +: 12]; // RULE7
  assign off_y = off_date[CTS_DATE_YEAR +: 12]; // RULE7
  assign on_md = {on_date[CTS_DATE_MON +: 4], on_date[CTS_DATE_DAY +: 5]};
  assign off_md = {off_date[CTS_DATE_MON +: 4], off_date[CTS_DATE_DAY +: 5]};
  assign now_md = {month, day};
  // An unset off year leaves the span open to the last accepted year
  assign in_span = (year >= on_y) && (year <= ((off_y == 12'd0) ? CTS_YEAR_MAX : off_y)); // RULE5

  // ==========================================================
  // Event decode per mode
  always_comb begin
    on_ev = 1'b0;
    off_ev = 1'b0;
    if (monthly) begin
      on_ev = in_span && (day == on_md[4:0]); // RULE8
      off_ev = in_span && (day == off_md[4:0]) && (off_md[4:0] != 5'd0); // RULE8
    end else if (yearly) begin
      on_ev = in_span && (now_md == on_md) && !(year == off_y && on_md > off_md); // RULE9 RULE13
      off_ev = (year >= on_y) && (year <= off_y) && (now_md == off_md); // RULE9 RULE13
    end else begin
      on_ev = ({year, now_md} == {on_y, on_md}); // RULE12
      off_ev = ({year, now_md} == {off_y, off_md}); // RULE12
    end
  end

  // ==========================================================
  // Output state, moved on the midnight tick, or on any tick to end a pulse
  always_comb begin
    q_nxt = q_r;
    done_nxt = rearm ? 1'b0 : done_r;
    if (tick && pulse) begin
      q_nxt = 1'b0; // RULE10
    end
    if (tick && midnight) begin // RULE6
      if (pulse) begin
        if (on_ev && !(done_r && !monthly && !yearly)) begin
          q_nxt = 1'b1; // RULE10 RULE11
          done_nxt = !monthly && !yearly; // RULE11
        end
      end else if (off_ev) begin
        q_nxt = 1'b0;
      end else if (on_ev) begin
        q_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
      done_r <= done_nxt;
    end
  end

  assign q = q_r;
  assign done = done_r;

  // ==========================================================
  // Checks
  rise_at_midnight_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
    $rose(q_r) |-> $past(tick && midnight))
    else $error("yearly output rose away from midnight");
  one_shot_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE11
    (done_r && !rearm && pulse && !monthly && !yearly) |=> !$rose(q_r))
    else $error("single pulse repeated");
  ypulse_width_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
    (q_r && pulse && tick && !midnight) |=> !q_r)
    else $error("yearly pulse outlived a program cycle");
  final_year_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE13
    (tick && midnight && yearly && !monthly && !pulse && !q_r && year == off_y && on_md > off_md)
    |=> !q_r)
    else $error("new period started in final year");
endmodule

// *** pkg/cts_pkg.sv ***
// Contract
// [RULE1] Each weekly cam holds seven weekday flags; a cleared flag blocks that day.
// [RULE2] Weekly on/off times are hour:minute at one-minute steps, 00:00 to 23:59.
// [RULE3] Weekly pulse mode asserts output for one program cycle; setting shared by cams.
// [RULE4] A time field marked empty is unset and never generates a switching event.
// [RULE5] Yearly dates are limited to years 2000 through 2099.
// [RULE6] Yearly timer switches only at 00:00 of the relevant date.
// [RULE7] Yearly dates are held as ordered fields: year, then month, then day.
// [RULE8] Monthly mode: on at on-day, off at off-day, each month within year span.
// [RULE9] Yearly mode: on at on month/day, off at off month/day, within year span.
// [RULE10] Yearly pulse mode asserts one program cycle at on-date, alone or repeating.
// [RULE11] Pulse without repetition emits exactly one pulse, then never again; the code re-arms it on any accepted date write or yearly control write.
// [RULE12] No mode selected: output on from full on-date until full off-date.
// [RULE13] Yearly wrap periods cross into next year; no new start after final off.
// [RULE14] Weekly sets output at on-time, resets at off-time or cycle end if pulse.
// [RULE15] Identical times on different cams: the highest-numbered cam wins.
// [RULE16] Every cam is compared with the clock once per program cycle; the code acts only on the first tick of each new minute.
// [RULE17] Weekly output is the combination of all three cams.
package cts_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTS_CAM0_OFS = 8'h00;
  localparam logic [7:0] CTS_CAM1_OFS = 8'h04;
  localparam logic [7:0] CTS_CAM2_OFS = 8'h08;
  localparam logic [7:0] CTS_WCTRL_OFS = 8'h0c;
  localparam logic [7:0] CTS_YON_OFS = 8'h10;
  localparam logic [7:0] CTS_YOFF_OFS = 8'h14;
  localparam logic [7:0] CTS_YCTRL_OFS = 8'h18;
  localparam logic [7:0] CTS_STATUS_OFS = 8'h1c;
  // ==========================================================
  // Cam word fields
  localparam int CTS_CAM_DAYS = 0;
  localparam int CTS_CAM_ON_SET = 7;
  localparam int CTS_CAM_ON_HR = 8;
  localparam int CTS_CAM_ON_MN = 13;
  localparam int CTS_CAM_OFF_SET = 19;
  localparam int CTS_CAM_OFF_HR = 20;
  localparam int CTS_CAM_OFF_MN = 25;
  // ==========================================================
  // Date word fields, year in the top field
  localparam int CTS_DATE_DAY = 0;
  localparam int CTS_DATE_MON = 8;
  localparam int CTS_DATE_YEAR = 16;
  // Control bits
  localparam int CTS_WCTRL_PULSE = 0;
  localparam int CTS_YCTRL_MONTHLY = 0;
  localparam int CTS_YCTRL_YEARLY = 1;
  localparam int CTS_YCTRL_PULSE = 2;
  // ==========================================================
  // Limits and reset values
  localparam logic [11:0] CTS_YEAR_MIN = 12'd2000;
  localparam logic [11:0] CTS_YEAR_MAX = 12'd2099;
  localparam logic [31:0] CTS_CAM_RST = 32'h0000_0000;
  localparam logic [31:0] CTS_YON_RST = 32'h07d0_0101;
  localparam logic [31:0] CTS_YOFF_RST = 32'h0833_0c1f;
  localparam logic [1:0] CTS_RESP_OKAY = 2'b00;
  localparam logic [1:0] CTS_RESP_SLVERR = 2'b10;
  localparam logic [1:0] CTS_RESP_DECERR = 2'b11;
endpackage

// *** sim/cts_prog_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Program side: counts yearly pulses seen at program ticks
module cts_prog_model (
  input wire logic clk, // Clock
  input wire logic reset_n, // Async reset, active low
  input wire logic cycle_tick, // Program cycle strobe
  input wire logic yearly_q, // Yearly switch output
  output logic [7:0] y_rises // Rising edges seen by program
);
  logic yq_r, yq_nxt;
  logic [7:0] y_rises_nxt;
  // Sample only on ticks, as the circuit program would
  always_comb begin
    yq_nxt = cycle_tick ? yearly_q : yq_r;
    y_rises_nxt = y_rises + 8'((cycle_tick && yearly_q && !yq_r) ? 1 : 0);
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      yq_r <= 1'b0;
      y_rises <= 8'h00;
    end else begin
      yq_r <= yq_nxt;
      y_rises <= y_rises_nxt;
    end
  end
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import cts_pkg::*;
  logic clk, reset_n, cycle_tick, weekly_q, yearly_q;
  logic [11:0] rtc_year;
  logic [3:0] rtc_month;
  logic [4:0] rtc_day, rtc_hour;
  logic [2:0] rtc_wday;
  logic [5:0] rtc_min;
  logic [7:0] s_axi_awaddr, s_axi_araddr, y_rises;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int n_mismatch, checked;
  cts_top dut (.*);
  cts_prog_model prog (.clk(clk), .reset_n(reset_n), .cycle_tick(cycle_tick), .yearly_q(yearly_q), .y_rises(y_rises));
  // ==========================================================
  // Common tasks
  task final_report();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait; a hang ends the run
  task wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    if (i == 40) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task rdw(input logic [7:0] a);
    int i;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    {rd, rsp} = {s_axi_rdata, s_axi_rresp};
    if (i == 40) begin
      n_mismatch++;
      final_report();
    end
  endtask
  // One program cycle with the given clock reading
  task tk(input int y, m, d, wd, h, mi);
    {rtc_year, rtc_month, rtc_day} <= {12'(y), 4'(m), 5'(d)};
    {rtc_wday, rtc_hour, rtc_min} <= {3'(wd), 5'(h), 6'(mi)};
    cycle_tick <= 1'b1;
    @(posedge clk);
    cycle_tick <= 1'b0;
    @(posedge clk);
  endtask
  // Midnight tick then 00:01, so each midnight is a fresh minute
  task md(input int y, m, d, input logic e);
    tk(y, m, d, 0, 0, 0);
    chk(32'(yearly_q), 32'(e));
    tk(y, m, d, 0, 0, 1);
  endtask
  function logic [31:0] cw(input logic [6:0] dy, input logic on, input logic [4:0] h1, input logic [5:0] m1,
                           input logic off, input logic [4:0] h2, input logic [5:0] m2);
    return {1'b0, m2, h2, off, m1, h1, on, dy};
  endfunction
  function logic [31:0] dt(input logic [11:0] y, input logic [3:0] m, input logic [4:0] d);
    return {4'h0, y, 4'h0, m, 3'h0, d};
  endfunction
  // ==========================================================
  // Scenarios
  task t_regs();
    rdw(CTS_YON_OFS);
    chk(rd, CTS_YON_RST);
    rdw(CTS_YOFF_OFS);
    chk(rd, CTS_YOFF_RST);
    rdw(8'h40);
    chk(32'(rsp), 32'(CTS_RESP_DECERR));
    wr(CTS_STATUS_OFS, 32'h0000_0001);
    chk(32'(rsp), 32'(CTS_RESP_SLVERR));
    wr(CTS_YON_OFS, dt(12'd2100, 4'h1, 5'h01));
    chk(32'(rsp), 32'(CTS_RESP_SLVERR));
    rdw(CTS_YON_OFS);
    chk(rd, CTS_YON_RST);
  endtask
  task t_weekly();
    wr(CTS_CAM0_OFS, cw(7'h02, 1, 5'd3, 6'd10, 1, 5'd4, 6'd15));
    wr(CTS_CAM1_OFS, cw(7'h7f, 1, 5'd23, 6'd59, 1, 5'd0, 6'd0));
    wr(CTS_CAM2_OFS, cw(7'h7f, 0, 5'd5, 6'd0, 0, 5'd5, 6'd30));
    tk(2009, 1, 5, 0, 3, 10);
    chk(32'(weekly_q), 32'h0);
    tk(2009, 1, 6, 1, 3, 9);
    tk(2009, 1, 6, 1, 3, 10);
    chk(32'(weekly_q), 32'h1);
    tk(2009, 1, 6, 1, 4, 15);
    chk(32'(weekly_q), 32'h0);
    tk(2009, 1, 6, 1, 5, 0);
    chk(32'(weekly_q), 32'h0);
    tk(2009, 1, 6, 1, 23, 59);
    chk(32'(weekly_q), 32'h1);
    tk(2009, 1, 7, 2, 0, 0);
    chk(32'(weekly_q), 32'h0);
  endtask
  task t_prio();
    wr(CTS_CAM0_OFS, cw(7'h7f, 1, 5'd6, 6'd0, 1, 5'd7, 6'd0));
    wr(CTS_CAM1_OFS, cw(7'h7f, 0, 5'd0, 6'd0, 1, 5'd6, 6'd0));
    tk(2009, 1, 7, 2, 6, 0);
    chk(32'(weekly_q), 32'h0);
    wr(CTS_CAM1_OFS, cw(7'h7f, 1, 5'd7, 6'd0, 0, 5'd0, 6'd0));
    tk(2009, 1, 7, 2, 7, 0);
    chk(32'(weekly_q), 32'h1);
  endtask
  task t_wpulse();
    wr(CTS_WCTRL_OFS, 32'h0000_0001);
    wr(CTS_CAM2_OFS, cw(7'h7f, 1, 5'd8, 6'd0, 0, 5'd0, 6'd0));
    tk(2009, 1, 7, 2, 7, 59);
    chk(32'(weekly_q), 32'h0);
    tk(2009, 1, 7, 2, 8, 0);
    chk(32'(weekly_q), 32'h1);
    tk(2009, 1, 7, 2, 8, 0);
    chk(32'(weekly_q), 32'h0);
    tk(2009, 1, 7, 2, 8, 1);
    chk(32'(weekly_q), 32'h0);
    wr(CTS_WCTRL_OFS, 32'h0);
  endtask
  task t_year(input logic [31:0] on, off, input logic [2:0] mode);
    wr(CTS_YON_OFS, on);
    wr(CTS_YOFF_OFS, off);
    wr(CTS_YCTRL_OFS, 32'(mode));
  endtask
  task t_yearly();
    t_year(dt(12'd2008, 4'd12, 5'd15), dt(12'd2010, 4'd1, 5'd7), 3'h2);
    tk(2009, 12, 15, 1, 10, 0);
    chk(32'(yearly_q), 32'h0);
    md(2009, 12, 15, 1'b1);
    md(2010, 1, 6, 1'b1);
    md(2010, 1, 7, 1'b0);
    md(2010, 12, 15, 1'b0);
  endtask
  task t_month_span();
    t_year(dt(12'd2008, 4'd1, 5'd1), dt(12'd2010, 4'd1, 5'd5), 3'h1);
    md(2009, 4, 1, 1'b1);
    md(2009, 4, 5, 1'b0);
    md(2011, 4, 1, 1'b0);
    t_year(dt(12'd2008, 4'd6, 5'd1), dt(12'd2010, 4'd8, 5'd31), 3'h0);
    md(2008, 6, 1, 1'b1);
    md(2009, 1, 1, 1'b1);
    md(2010, 8, 31, 1'b0);
  endtask
  task t_pulse();
    logic [7:0] c0;
    t_year(dt(12'd2008, 4'd3, 5'd15), dt(12'd2099, 4'd12, 5'd31), 3'h4);
    c0 = y_rises;
    md(2008, 3, 15, 1'b1);
    chk(32'(yearly_q), 32'h0);
    md(2008, 3, 15, 1'b0);
    md(2009, 3, 15, 1'b0);
    chk(32'(y_rises - c0), 32'h1);
    wr(CTS_YCTRL_OFS, 32'h6);
    md(2010, 3, 15, 1'b1);
    md(2011, 3, 15, 1'b1);
    wr(CTS_YCTRL_OFS, 32'h5);
    md(2012, 4, 15, 1'b1);
  endtask
  // ==========================================================
  // Clock, reset and main sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {reset_n, cycle_tick, rtc_year, rtc_month, rtc_day, rtc_wday, rtc_hour, rtc_min} = {2'b00, 12'd2009, 4'd1, 5'd5, 14'h0};
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = {8'h00, 1'b0, 32'h0, 4'hf, 2'b00};
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = {8'h00, 2'b00};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_weekly();
    t_prio();
    t_wpulse();
    t_yearly();
    t_month_span();
    t_pulse();
    final_report();
  end
endmodule
